// >>> src/epf_cfg.svh
`ifndef EPF_CFG_SVH
`define EPF_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EPF_OFS_CTRL0   8'h00
`define EPF_OFS_CNT0    8'h04
`define EPF_TMR_STRIDE  8'h08
`define EPF_OFS_PORT    8'h10
`define EPF_OFS_INTEN   8'h14
`define EPF_OFS_STATUS  8'h18
// ----------------------------------------
// Field positions, reset values and counter constants
// ----------------------------------------
`define EPF_PORT_DATA_LSB 8
`define EPF_PFD_BIT       7
`define EPF_CTRL_RST      8'h00
`define EPF_PRELOAD_RST   8'h00
`define EPF_DIR_RST       8'hFF
`define EPF_DATA_RST      8'h00
`define EPF_CNT_FULL      8'hFF
`define EPF_CNT_ONE       8'h01
`define EPF_PSC_ALL       8'hFF
`endif

// >>> src/epf_pkg.sv
`default_nettype none

package epf_pkg;
    typedef enum logic [1:0] {
        EPF_MODE_IDLE  = 2'h0,
        EPF_MODE_EVENT = 2'h1,
        EPF_MODE_TIMER = 2'h2,
        EPF_MODE_PULSE = 2'h3
    } epf_mode_t;

    typedef struct packed {
        epf_mode_t  mode;
        logic       rsvd;
        logic       run;
        logic       edge_sel;
        logic [2:0] prescale_sel;
    } epf_ctrl_t;
endpackage

`default_nettype wire

// >>> src/epf_timer.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "epf_cfg.svh"

module epf_timer #(
    parameter bit PFD_EN = 1'b1
) (
    input  wire logic        ref_clk_in,             // 125 MHz clock
    input  wire logic        srst_in,                // Sync reset, high
    input  wire logic [7:0]  avs_address_in,         // Byte address
    input  wire logic        avs_read_in,            // Read request
    input  wire logic        avs_write_in,           // Write request
    input  wire logic [31:0] avs_writedata_in,       // Write data
    output logic      [31:0] avs_readdata_out,       // Read data
    output logic             avs_waitrequest_out,    // Wait request
    input  wire logic        counter0_input_pin_in,  // Counter 0 pin
    input  wire logic        counter1_input_pin_in,  // Counter 1 pin
    input  wire logic        powerdown_in,           // Core powered down
    output logic      [1:0]  irq_out,                // Overflow irq pulse
    output logic             wake_out,               // Wake-up pulse
    output logic             port_a_bit7_out,        // Shared pin level
    output logic             port_a_bit7_oe_out      // Shared pin enable
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic psc_tick(input logic [7:0] cnt, input logic [2:0] sel);
        logic [7:0] mask;
        mask = 8'((`EPF_CNT_ONE << sel) - `EPF_CNT_ONE);
        return (cnt | ~mask) == `EPF_PSC_ALL;
    endfunction

    function automatic logic edge_pick(input logic rise, input logic fall, input logic sel);
        return sel ? fall : rise;
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        req;
    logic        wr_go;
    logic [31:0] rdata_d;

    assign req   = avs_read_in | avs_write_in;
    // One wait cycle gives a registered read mux
    assign wr_go = avs_write_in & ~wait_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            wait_q  <= ~(req & wait_q);
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out    = rdata_q;

    // ----------------------------------------
    // Port and interrupt enables
    // ----------------------------------------
    logic [7:0] dir_q;
    logic [7:0] data_q;
    logic [1:0] inten_q;
    logic       pfd_q;
    logic       pin_q;
    logic       oe_q;
    logic       wr_port;
    logic       wr_inten;

    assign wr_port  = wr_go & (avs_address_in == `EPF_OFS_PORT);
    assign wr_inten = wr_go & (avs_address_in == `EPF_OFS_INTEN);

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            dir_q   <= `EPF_DIR_RST;
            data_q  <= `EPF_DATA_RST;
            inten_q <= 2'h0;
        end
        else
        begin
            if (wr_port)
            begin
                dir_q  <= avs_writedata_in[7:0];
                data_q <= avs_writedata_in[`EPF_PORT_DATA_LSB +: 8];
            end
            if (wr_inten)
                inten_q <= avs_writedata_in[1:0];
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] prev_q;
    logic [1:0] rise;
    logic [1:0] fall;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q  <= 2'h0;
        end
        else
        begin
            sync1_q <= {counter1_input_pin_in, counter0_input_pin_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // The second stage and its delayed copy prev_q feed the edge detectors
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    epf_pkg::epf_ctrl_t ctrl_q [2];
    logic [7:0]         cnt_q  [2];
    logic [7:0]         pre_q  [2];
    logic [7:0]         psc_q  [2];
    logic [1:0]         meas_q;
    logic [1:0]         ovf;
    logic [1:0]         inc;
    logic [1:0]         stop;
    logic [1:0]         evt_ovf;
    logic [1:0]         irq_q;
    logic               wake_q;

    for (genvar i = 0; i < 2; i++)
    begin : g_tmr
        logic [7:0] ofs_ctrl;
        logic [7:0] ofs_cnt;
        logic       wr_ctrl;
        logic       wr_pre;
        logic       tick;
        logic       ev_edge;
        logic       start;
        logic       is_evt;
        logic       is_tmr;
        logic       is_pwm;

        assign ofs_ctrl = 8'(`EPF_OFS_CTRL0 + i * `EPF_TMR_STRIDE);
        assign ofs_cnt  = 8'(`EPF_OFS_CNT0 + i * `EPF_TMR_STRIDE);
        assign wr_ctrl  = wr_go & (avs_address_in == ofs_ctrl);
        assign wr_pre   = wr_go & (avs_address_in == ofs_cnt);
        assign is_evt   = ctrl_q[i].mode == epf_pkg::EPF_MODE_EVENT;
        assign is_tmr   = ctrl_q[i].mode == epf_pkg::EPF_MODE_TIMER;
        assign is_pwm   = ctrl_q[i].mode == epf_pkg::EPF_MODE_PULSE;
        assign tick     = psc_tick(psc_q[i], ctrl_q[i].prescale_sel);
        assign ev_edge  = edge_pick(rise[i], fall[i], ctrl_q[i].edge_sel);
        assign start    = edge_pick(fall[i], rise[i], ctrl_q[i].edge_sel);
        assign stop[i]  = is_pwm & meas_q[i] & ev_edge;
        // Event edges bypass the prescaler entirely
        assign inc[i]   = ctrl_q[i].run & ((is_evt & ev_edge)
                        | (is_tmr & tick) | (is_pwm & meas_q[i] & tick));
        assign ovf[i]   = inc[i] & (cnt_q[i] == `EPF_CNT_FULL);
        assign evt_ovf[i] = ovf[i] & is_evt;

        always_ff @(posedge ref_clk_in)
        begin
            if (srst_in)
            begin
                ctrl_q[i] <= `EPF_CTRL_RST;
                pre_q[i]  <= `EPF_PRELOAD_RST;
                cnt_q[i]  <= `EPF_PRELOAD_RST;
                psc_q[i]  <= 8'h00;
                meas_q[i] <= 1'b0;
                irq_q[i]  <= 1'b0;
            end
            else
            begin
                psc_q[i] <= psc_q[i] + 8'h01;
                irq_q[i] <= ovf[i] & inten_q[i];
                // Software write wins over the hardware stop
                if (wr_ctrl)
                begin
                    ctrl_q[i] <= avs_writedata_in[7:0];
                    meas_q[i] <= 1'b0;
                end
                else if (stop[i])
                    ctrl_q[i].run <= 1'b0;
                if (!wr_ctrl && is_pwm && ctrl_q[i].run && !meas_q[i] && start)
                    meas_q[i] <= 1'b1;
                else if (!wr_ctrl && stop[i])
                    meas_q[i] <= 1'b0;
                if (wr_pre)
                    pre_q[i] <= avs_writedata_in[7:0];
                if (wr_pre && !ctrl_q[i].run)
                    cnt_q[i] <= avs_writedata_in[7:0];
                else if (ovf[i])
                    cnt_q[i] <= pre_q[i];
                else if (inc[i])
                    cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end

        a_evt_count_inc: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            inc[i] && is_evt && !ovf[i] && !wr_pre |=> cnt_q[i] == $past(cnt_q[i]) + 8'h01)
            else $error("event edge did not increment");
        a_ovf_reload: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            ovf[i] && !(wr_pre && !ctrl_q[i].run) |=> cnt_q[i] == $past(pre_q[i]))
            else $error("overflow did not reload");
        a_irq_gate: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            irq_out[i] |-> $past(ovf[i]) && $past(inten_q[i]))
            else $error("irq without enabled overflow");
        a_run_hold_sw: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            !is_pwm && ctrl_q[i].run && !wr_ctrl |=> ctrl_q[i].run)
            else $error("run cleared by hardware");
        a_evt_no_psc: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            is_evt && !ev_edge && !wr_pre && !wr_ctrl |=> $stable(cnt_q[i]))
            else $error("event counter moved without edge");
        a_stop_preload: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            wr_pre && !ctrl_q[i].run |=> cnt_q[i] == $past(avs_writedata_in[7:0]))
            else $error("stopped preload write not loaded");

        sequence s_armed;
            is_pwm && ctrl_q[i].run && !meas_q[i] && start && !wr_ctrl;
        endsequence
        sequence s_stopped;
            stop[i] && !wr_ctrl ##1 !ctrl_q[i].run && !meas_q[i];
        endsequence
        a_pwm_start: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            s_armed |=> meas_q[i])
            else $error("pulse measure did not start");
        a_pwm_stop: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            stop[i] && !wr_ctrl |-> s_stopped)
            else $error("pulse measure did not stop");
        a_pwm_hold: assert property (@(posedge ref_clk_in)
            disable iff (srst_in)
            s_stopped ##1 !wr_ctrl && !wr_pre |=> $stable(cnt_q[i]))
            else $error("measured count not held");
    end

    assign irq_out = irq_q;

    // ----------------------------------------
    // Wake-up and frequency divider
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            wake_q <= 1'b0;
            pfd_q  <= 1'b0;
            pin_q  <= 1'b0;
            oe_q   <= 1'b0;
        end
        else
        begin
            wake_q <= powerdown_in & (|evt_ovf);
            if (ovf[1])
                pfd_q <= ~pfd_q;
            oe_q  <= ~dir_q[`EPF_PFD_BIT];
            // Data bit acts as on/off gate for the divider
            pin_q <= data_q[`EPF_PFD_BIT] & (PFD_EN ? pfd_q : 1'b1);
        end
    end

    assign wake_out           = wake_q;
    assign port_a_bit7_out    = pin_q;
    assign port_a_bit7_oe_out = oe_q;

    a_wake_evt: assert property (@(posedge ref_clk_in)
        disable iff (srst_in)
        powerdown_in && (|evt_ovf) |=> wake_out)
        else $error("event overflow did not wake");
    a_pfd_toggle: assert property (@(posedge ref_clk_in)
        disable iff (srst_in)
        ovf[1] |=> pfd_q != $past(pfd_q))
        else $error("divider did not toggle");
    a_pin_gate_low: assert property (@(posedge ref_clk_in)
        disable iff (srst_in)
        !data_q[`EPF_PFD_BIT] |=> !port_a_bit7_out)
        else $error("pin not held low");

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] status_w;

    assign status_w = {26'h0, pfd_q, meas_q, sync2_q, 1'b0};

    always_comb
    begin
        rdata_d = 32'h0;
        if (avs_address_in == `EPF_OFS_CTRL0)
            rdata_d = {24'h0, ctrl_q[0]};
        else if (avs_address_in == `EPF_OFS_CNT0)
            rdata_d = {24'h0, cnt_q[0]};
        else if (avs_address_in == `EPF_OFS_CTRL0 + `EPF_TMR_STRIDE)
            rdata_d = {24'h0, ctrl_q[1]};
        else if (avs_address_in == `EPF_OFS_CNT0 + `EPF_TMR_STRIDE)
            rdata_d = {24'h0, cnt_q[1]};
        else if (avs_address_in == `EPF_OFS_PORT)
            rdata_d = {16'h0, data_q, dir_q};
        else if (avs_address_in == `EPF_OFS_INTEN)
            rdata_d = {30'h0, inten_q};
        else if (avs_address_in == `EPF_OFS_STATUS)
            rdata_d = status_w;
    end
endmodule

`default_nettype wire

// >>> tb/epf_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module epf_pin_model (
    input  wire logic       ref_clk_in,  // Bench clock
    input  wire logic       idle_lvl_in, // Level between pulses
    input  wire logic       start_in,    // Begin a pulse train
    input  wire logic [7:0] width_in,    // Cycles per phase
    input  wire logic [7:0] pulses_in,   // Pulses in the train
    output logic            pin_out,     // Timer pin level
    output logic            busy_out     // Train in progress
);
    // ------
    // Pulse train
    // ------
    logic [7:0] left_q = 8'h00;
    logic [7:0] cnt_q  = 8'h00;
    logic       act_q  = 1'b0;

    // Idle level stands in for a pull, still valid on a timer input
    assign pin_out  = idle_lvl_in ^ act_q;
    assign busy_out = (left_q != 8'h00);

    always @(posedge ref_clk_in)
    begin
        if (start_in && !busy_out)
        begin
            left_q <= pulses_in;
            cnt_q  <= width_in;
            act_q  <= 1'b1;
        end
        else if (busy_out && cnt_q > 8'h01)
            cnt_q <= cnt_q - 8'h01;
        else if (busy_out)
        begin
            cnt_q <= width_in;
            act_q <= ~act_q;
            if (act_q)
                left_q <= left_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "epf_cfg.svh"

module tb;
    logic        clk  = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  adr  = 8'h00;
    logic        rd   = 1'b0;
    logic        wr   = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic        pd   = 1'b1;
    logic [1:0]  idle = 2'h0;
    logic [1:0]  go   = 2'h0;
    logic [7:0]  wid  = 8'h03;
    logic [7:0]  npl  = 8'h01;
    logic [31:0] rv;
    wire  [31:0] rdat;
    wire         wreq;
    wire  [1:0]  pin;
    wire  [1:0]  busy;
    wire  [1:0]  irq;
    wire         wake;
    wire         pa7;
    wire         pa7_oe;
    int          n_irq [2] = '{0, 0};
    int          n_wake    = 0;
    int          n_errors  = 0;
    int          checked   = 0;

    always #4 clk = ~clk;

    epf_timer #(.PFD_EN(1'b1)) epf_timer_i (
        .ref_clk_in(clk), .srst_in(srst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .counter0_input_pin_in(pin[0]), .counter1_input_pin_in(pin[1]),
        .powerdown_in(pd), .irq_out(irq), .wake_out(wake),
        .port_a_bit7_out(pa7), .port_a_bit7_oe_out(pa7_oe));

    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        epf_pin_model u (.ref_clk_in(clk), .idle_lvl_in(idle[g]), .start_in(go[g]),
            .width_in(wid), .pulses_in(npl), .pin_out(pin[g]), .busy_out(busy[g]));
    end

    // Counted mid-cycle so tasks never race the pulse edge
    always @(negedge clk)
    begin
        if (irq[0] === 1'b1) n_irq[0]++;
        if (irq[1] === 1'b1) n_irq[1]++;
        if (wake === 1'b1) n_wake++;
    end

    // ------
    // Bus and check tasks
    // ------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic quit(input string nm);
        n_errors++;
        $display("BAD %s expected done seen timeout", nm);
        tally_and_finish();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
                       input int tol = 0);
        checked++;
        if ((g + tol < e) !== 1'b0 || (g > e + tol) !== 1'b0)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        adr  <= a;
        wdat <= d;
        wr   <= w;
        rd   <= !w;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        rv = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (i == 20) quit("waitrequest");
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e,
                      input int tol = 0);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rv, tol);
    endtask

    task automatic lvl(input int k, input logic v);
        @(posedge clk);
        idle[k] <= v;
        repeat (6) @(posedge clk);
    endtask

    task automatic pulse(input int k, input logic [7:0] width, input logic [7:0] n);
        int i;
        @(posedge clk);
        wid   <= width;
        npl   <= n;
        go[k] <= 1'b1;
        @(posedge clk);
        go[k] <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 2000 && busy[k] !== 1'b0; i++) @(posedge clk);
        if (i == 2000) quit("pulse");
        repeat (6) @(posedge clk);
    endtask

    // ------
    // Scenarios
    // ------
    task automatic ev_test(input int k, input logic e, input logic ie);
        logic [7:0]  ca;
        logic [31:0] c;
        int          i0;
        int          w0;
        ca = `EPF_OFS_CTRL0 + 8'(k) * `EPF_TMR_STRIDE;
        c  = 32'h47 | 32'(e) << 3;
        // Powered down only with the irq enabled, so both wake outcomes are seen
        pd <= ie;
        w(`EPF_OFS_INTEN, 32'(ie) << k);
        w(ca + `EPF_OFS_CNT0, 32'hFC);
        rc(ca + `EPF_OFS_CNT0, "cnt_load", 32'hFC);
        w(ca, c);
        w(ca, c | 32'h10);
        i0 = n_irq[k];
        w0 = n_wake;
        lvl(k, 1'b1);
        rc(ca + `EPF_OFS_CNT0, "cnt_edge", e ? 32'hFC : 32'hFD);
        lvl(k, 1'b0);
        pulse(k, 8'h03, 8'h02);
        rc(ca + `EPF_OFS_CNT0, "cnt_full", 32'hFF);
        w(ca + `EPF_OFS_CNT0, 32'hF0);
        rc(ca + `EPF_OFS_CNT0, "cnt_run_pre", 32'hFF);
        pulse(k, 8'h03, 8'h01);
        rc(ca + `EPF_OFS_CNT0, "cnt_reload", 32'hF0);
        chk("irq", 32'(ie), 32'(n_irq[k] - i0));
        chk("wake", 32'(ie), 32'(n_wake - w0));
        rc(ca, "ctrl_run", c | 32'h10);
        w(ca, 32'h0);
        pd <= 1'b1;
        $display("event test on counter %0d done", k);
    endtask

    task automatic pw_test(input int k, input logic e, input logic [2:0] ps);
        logic [7:0]  ca;
        logic [31:0] c;
        logic [31:0] m;
        ca = `EPF_OFS_CTRL0 + 8'(k) * `EPF_TMR_STRIDE;
        c  = 32'hC0 | 32'(e) << 3 | 32'(ps);
        lvl(k, !e);
        w(ca + `EPF_OFS_CNT0, 32'h0);
        w(ca, c);
        w(ca, c | 32'h10);
        repeat (10) @(posedge clk);
        rc(ca + `EPF_OFS_CNT0, "cnt_armed", 32'h0);
        pulse(k, 8'h28, 8'h01);
        rc(ca + `EPF_OFS_CNT0, "cnt_width", 32'(8'h28 >> ps), 1);
        m = rv;
        rc(ca, "ctrl_stop", c);
        pulse(k, 8'h28, 8'h01);
        rc(ca + `EPF_OFS_CNT0, "cnt_hold", m);
        $display("pulse test on counter %0d done", k);
    endtask

    task automatic pfd_test;
        int   i;
        int   n;
        int   i1;
        int   w0;
        logic p;
        w(`EPF_OFS_PORT, 32'h807F);
        repeat (3) @(posedge clk);
        chk("oe_on", 32'h1, 32'(pa7_oe));
        w(`EPF_OFS_INTEN, 32'h2);
        w(8'h0C, 32'hF0);
        w(8'h08, 32'h80);
        w(8'h08, 32'h90);
        w0 = n_wake;
        p  = pa7;
        for (i = 0; i < 100 && pa7 === p; i++) @(posedge clk);
        if (i == 100) quit("divider");
        i1 = n_irq[1];
        for (n = 0; n < 4; n++)
        begin
            p = pa7;
            for (i = 0; i < 100 && pa7 === p; i++) @(posedge clk);
            chk("pfd_period", 32'h10, 32'(i));
        end
        chk("pfd_irq", 32'h4, 32'(n_irq[1] - i1));
        chk("pfd_wake", 32'h0, 32'(n_wake - w0));
        w(`EPF_OFS_PORT, 32'h007F);
        repeat (3) @(posedge clk);
        n = 0;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if (pa7 !== 1'b0) n++;
        end
        chk("pfd_gated", 32'h0, 32'(n));
        w(`EPF_OFS_PORT, 32'h00FF);
        repeat (3) @(posedge clk);
        chk("oe_off", 32'h0, 32'(pa7_oe));
        w(8'h08, 32'h0);
        $display("divider test done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rc(`EPF_OFS_CTRL0, "ctrl0_rst", 32'h0);
        rc(`EPF_OFS_PORT, "port_rst", 32'hFF);
        rc(`EPF_OFS_STATUS, "status_rst", 32'h0);
        w(`EPF_OFS_CNT0, 32'h05);
        w(`EPF_OFS_CTRL0, 32'h10);
        lvl(0, 1'b1);
        lvl(0, 1'b0);
        rc(`EPF_OFS_CNT0, "cnt_idle", 32'h05);
        w(`EPF_OFS_CTRL0, 32'h0);
        w(8'h1C, 32'hFFFF_FFFF);
        rc(8'h1C, "unmapped", 32'h0);
        chk("oe_rst", 32'h0, 32'(pa7_oe));
        $display("reset test done");
        ev_test(0, 1'b0, 1'b1);
        ev_test(1, 1'b1, 1'b0);
        pw_test(0, 1'b0, 3'h0);
        pw_test(1, 1'b1, 3'h2);
        pfd_test();
        tally_and_finish();
    end
endmodule
`default_nettype wire
